// ### shared/ext_irq_pkg.sv
// Purpose: constants, types and helpers shared by the external interrupt block
// Assumes: 32-bit AHB-Lite register bus, nine candidate pins over four channels
// Notes:   register offsets are full byte addresses, one aligned word each
package ext_irq_pkg;
   localparam int          NUM_CH       = 4;
   localparam int          NUM_PINS     = 9;
   localparam int          REG_W        = 8;
   typedef logic [NUM_CH-1:0]   ch_vec_t;
   typedef logic [NUM_PINS-1:0] pin_vec_t;
   // register byte addresses
   localparam logic [31:0] FLAGS_ADDR   = 32'hE01FC140;
   localparam logic [31:0] WAKE_ADDR    = 32'hE01FC144;
   localparam logic [31:0] SENS_ADDR    = 32'hE01FC148;
   localparam logic [31:0] POL_ADDR     = 32'hE01FC14C;
   // used field sits in bits 3:0, bits 7:4 reserved
   localparam int          FIELD_LSB    = 0;
   localparam int          FIELD_MSB    = 3;
   localparam ch_vec_t     FLAGS_RST    = 4'h0;
   localparam ch_vec_t     WAKE_RST     = 4'h0;
   localparam ch_vec_t     SENS_RST     = 4'h0;
   localparam ch_vec_t     POL_RST      = 4'h0;
   localparam logic        SENS_LEVEL   = 1'b0;
   localparam logic        SENS_EDGE    = 1'b1;
   localparam logic        POL_LOW      = 1'b0;
   localparam logic        POL_HIGH     = 1'b1;
   // candidate pins of each channel: ch0 pins 1:0, ch1 3:2, ch2 5:4, ch3 8:6
   localparam pin_vec_t    CH_PIN_MASK [NUM_CH] = '{9'h003, 9'h00C, 9'h030, 9'h1C0};
   // bus encodings
   localparam logic [2:0]  HSIZE_WORD   = 3'h2;
   localparam logic        HRESP_OKAY   = 1'b0;
   localparam logic [31:0] RDATA_NONE   = 32'h00000000;

   // true when any pin of the mask is set in the vector
   function automatic logic any_hit(input pin_vec_t mask, input pin_vec_t vec);
      return |(mask & vec);
   endfunction
endpackage

// ### shared/ext_irq_links_if.sv
// Purpose: carriers between the bus slave, the pin sampler and the register core
// Assumes: all signals on hclk
// Notes:   wr is a one-cycle strobe with addr and wdata beside it
`timescale 1ns/10ps
interface reg_bus_if;
   logic        wr;
   logic [31:0] addr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   modport master (output wr, addr, wdata, input rdata);
   modport target (input wr, addr, wdata, output rdata);
endinterface

interface pin_evt_if;
   logic [8:0] level;
   logic [8:0] rise;
   logic [8:0] fall;
   modport src (output level, rise, fall);
   modport dst (input level, rise, fall);
endinterface

// ### hw/ext_irq_pin_sync.sv
// Purpose: bring the raw pins onto hclk and mark their edges
// Assumes: pins are asynchronous to hclk
// Notes:   level and edges appear one to two cycles after the pin moves
`timescale 1ns/10ps
module ext_irq_pin_sync
   import ext_irq_pkg::*;
(
   input  wire logic              hclk,
   input  wire logic              hresetn,
   input  wire ext_irq_pkg::pin_vec_t pin_raw,
   pin_evt_if.src                 evt
);
   pin_vec_t meta_r, meta_nxt;
   pin_vec_t sync_r, sync_nxt;
   pin_vec_t prev_r, prev_nxt;

   // two-stage synchroniser plus one stage of history
   always_comb begin
      meta_nxt = pin_raw;
      sync_nxt = meta_r;
      prev_nxt = sync_r;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_r <= '0;
         sync_r <= '0;
         prev_r <= '0;
      end else begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
         prev_r <= prev_nxt;
      end
   end

   // edges from successive synchronised samples
   assign evt.level = sync_r;
   assign evt.rise  = sync_r & ~prev_r;  // R20
   assign evt.fall  = ~sync_r & prev_r;  // R20
endmodule

// ### hw/ext_irq_ahb_slave.sv
// Purpose: AHB-Lite slave front end for the external interrupt registers
// Assumes: single slave, word transfers
// Notes:   writes take no wait state, reads take one; response always OKAY
`timescale 1ns/10ps
module ext_irq_ahb_slave
   import ext_irq_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   reg_bus_if.master        bus
);
   typedef enum logic [3:0] {
      ST_IDLE    = 4'h1,
      ST_WRITE   = 4'h2,
      ST_RD_WAIT = 4'h4,
      ST_RD_DONE = 4'h8
   } bus_state_t;

   bus_state_t  state_r, state_nxt;
   logic [31:0] addr_r,  addr_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic        accept;

   // address phase taken on nonseq or seq with the bus ready
   assign accept = hsel && hready && htrans[1];

   // next state, captured address and read data
   always_comb begin
      state_nxt = state_r;
      addr_nxt  = addr_r;
      rdata_nxt = rdata_r;
      case (state_r)
         ST_RD_WAIT: begin
            rdata_nxt = bus.rdata;
            state_nxt = ST_RD_DONE;
         end
         ST_IDLE, ST_WRITE, ST_RD_DONE: begin
            state_nxt = ST_IDLE;
            if (accept) begin
               addr_nxt = haddr;
               if (!hwrite)
                  state_nxt = ST_RD_WAIT;
               else if (hsize == HSIZE_WORD)
                  state_nxt = ST_WRITE;  // narrower writes are dropped
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r <= ST_IDLE;
         addr_r  <= '0;
         rdata_r <= RDATA_NONE;
      end else begin
         state_r <= state_nxt;
         addr_r  <= addr_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // strobes toward the register core and bus answers
   assign bus.wr    = (state_r == ST_WRITE);
   assign bus.addr  = addr_r;
   assign bus.wdata = hwdata;
   assign hreadyout = (state_r != ST_RD_WAIT);
   assign hrdata    = rdata_r;
   assign hresp     = HRESP_OKAY;
endmodule

// ### hw/ext_irq_top.sv
// Purpose: four external interrupt channels with flags, wake enables and modes
// Assumes: pin_routed comes from the pin mux on hclk; pin_in is asynchronous
// Notes:   flag set always beats a write-one clear in the same cycle
//
// Summary of operation
// R01: four independent channels 0 to 3, each a pin alternate function.
// R02: flag sets only from a routed pin showing the selected level or edge.
// R03: level mode sets the flag and holds it while the active level lasts.
// R04: edge mode sets the flag on the chosen edge; it holds until cleared.
// R05: each set flag drives its request line toward the interrupt controller.
// R06: writing one to flag bits 3:0 clears those flags.
// R07: in level mode a clear has no lasting effect while the pin stays active.
// R08: channels 0 to 2 take two candidate pins, channel 3 takes three.
// R09: software clears a flag after handling its wakeup or interrupt.
// R10: software clears a flag after any sensitivity or polarity change.
// R11: power-down entry fails while a wake-causing flag stays set.
// R12: one wake-enable bit per channel, four in total.
// R13: per-channel sensitivity picks level or edge detection.
// R14: per-channel polarity picks the active level or the active edge.
// R15: flag bits 7:4 are reserved; software writes no ones there.
// R16: all four registers reset their used bits to zero.
// R17: sensitivity 0 means level, 1 means edge.
// R18: polarity 0 means low or falling, 1 means high or rising.
// R19: wake-enabled channel wakes the processor regardless of its controller enable.
// R20: pins synchronised to hclk, edges from successive samples, then polarity.
`timescale 1ns/10ps
module ext_irq_top
   import ext_irq_pkg::*;
(
   input  wire logic                  hclk,
   input  wire logic                  hresetn,
   input  wire logic                  hsel,
   input  wire logic [31:0]           haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic                  hready,
   input  wire logic [31:0]           hwdata,
   output logic                       hreadyout,
   output logic [31:0]                hrdata,
   output logic                       hresp,
   input  wire ext_irq_pkg::pin_vec_t pin_in,
   input  wire ext_irq_pkg::pin_vec_t pin_routed,
   output ext_irq_pkg::ch_vec_t       irq_req,
   output logic                       wake_req,
   input  wire logic                  pd_entry_req,
   output logic                       pd_entry_ok
);
   reg_bus_if bus ();
   pin_evt_if evt ();

   ch_vec_t flags_r, flags_nxt;
   ch_vec_t wake_r,  wake_nxt;
   ch_vec_t sens_r,  sens_nxt;
   ch_vec_t pol_r,   pol_nxt;
   logic    wake_req_r, wake_req_nxt;
   ch_vec_t lvl_hit;
   ch_vec_t edge_hit;
   ch_vec_t set_evt;
   ch_vec_t clr_req;
   ch_vec_t routed_any;
   logic    pd_inhibit;

   // bus front end
   ext_irq_ahb_slave u_slave (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (hsize),
      .hready    (hready),
      .hwdata    (hwdata),
      .hreadyout (hreadyout),
      .hrdata    (hrdata),
      .hresp     (hresp),
      .bus       (bus.master)
   );

   // pin sampling onto hclk
   ext_irq_pin_sync u_sync (
      .hclk    (hclk),
      .hresetn (hresetn),
      .pin_raw (pin_in),
      .evt     (evt.src)
   );

   // per-channel detection over the routed candidate pins
   always_comb begin
      for (int c = 0; c < NUM_CH; c++) begin  // R01
         routed_any[c] = any_hit(CH_PIN_MASK[c], pin_routed);  // R08
         if (pol_r[c] == POL_HIGH) begin  // R18
            lvl_hit[c]  = any_hit(CH_PIN_MASK[c], pin_routed & evt.level);  // R14
            edge_hit[c] = any_hit(CH_PIN_MASK[c], pin_routed & evt.rise);   // R14
         end else begin
            lvl_hit[c]  = any_hit(CH_PIN_MASK[c], pin_routed & ~evt.level);
            edge_hit[c] = any_hit(CH_PIN_MASK[c], pin_routed & evt.fall);
         end
         // R13 R17
         set_evt[c] = (sens_r[c] == SENS_EDGE) ? edge_hit[c] : lvl_hit[c];  // R02
      end
   end

   // write-one clear of the flags, reserved bits ignored
   assign clr_req = (bus.wr && bus.addr == FLAGS_ADDR) ?
                    bus.wdata[FIELD_MSB:FIELD_LSB] : FLAGS_RST;  // R06 R15

   // next register values; set wins over a clear in the same cycle
   always_comb begin
      flags_nxt = set_evt | (flags_r & ~clr_req);  // R03 R04 R07
      wake_nxt  = wake_r;
      sens_nxt  = sens_r;
      pol_nxt   = pol_r;
      if (bus.wr) begin
         case (bus.addr)
            WAKE_ADDR: wake_nxt = bus.wdata[FIELD_MSB:FIELD_LSB];  // R12
            SENS_ADDR: sens_nxt = bus.wdata[FIELD_MSB:FIELD_LSB];  // R13
            POL_ADDR:  pol_nxt  = bus.wdata[FIELD_MSB:FIELD_LSB];  // R14
            default:   wake_nxt = wake_r;
         endcase
      end
      wake_req_nxt = |(flags_r & wake_r);  // R19
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flags_r    <= FLAGS_RST;  // R16
         wake_r     <= WAKE_RST;
         sens_r     <= SENS_RST;
         pol_r      <= POL_RST;
         wake_req_r <= 1'b0;
      end else begin
         flags_r    <= flags_nxt;
         wake_r     <= wake_nxt;
         sens_r     <= sens_nxt;
         pol_r      <= pol_nxt;
         wake_req_r <= wake_req_nxt;
      end
   end

   // read mux: used bits low, reserved and unmapped read zero
   always_comb begin
      bus.rdata = RDATA_NONE;
      case (bus.addr)
         FLAGS_ADDR: bus.rdata[FIELD_MSB:FIELD_LSB] = flags_r;  // R15
         WAKE_ADDR:  bus.rdata[FIELD_MSB:FIELD_LSB] = wake_r;
         SENS_ADDR:  bus.rdata[FIELD_MSB:FIELD_LSB] = sens_r;
         POL_ADDR:   bus.rdata[FIELD_MSB:FIELD_LSB] = pol_r;
         default:    bus.rdata = RDATA_NONE;
      endcase
   end

   // requests, wakeup and the power-down gate
   assign irq_req     = flags_r;  // R05
   assign wake_req    = wake_req_r;
   assign pd_inhibit  = |(flags_r & wake_r);  // R11
   assign pd_entry_ok = pd_entry_req && !pd_inhibit;  // R11

   // checks on the channel logic and the bus read wait
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   for (genvar c = 0; c < NUM_CH; c++) begin : g_chk
      property p_edge_sets;
         (sens_r[c] == SENS_EDGE) && edge_hit[c] |=> irq_req[c];
      endproperty
      a_edge_sets: assert property (p_edge_sets)  // R04
         else $error("edge event did not raise the request");

      property p_edge_holds;
         (sens_r[c] == SENS_EDGE) && flags_r[c] && !clr_req[c] |=> flags_r[c];
      endproperty
      a_edge_holds: assert property (p_edge_holds)  // R04
         else $error("edge flag dropped without a clear");

      property p_level_follow;
         ((sens_r[c] == SENS_LEVEL) && lvl_hit[c]) [*2] |=> flags_r[c];
      endproperty
      a_level_follow: assert property (p_level_follow)  // R03
         else $error("active level did not hold the flag");

      property p_level_noclr;
         (sens_r[c] == SENS_LEVEL) && lvl_hit[c] && clr_req[c] |=> flags_r[c];
      endproperty
      a_level_noclr: assert property (p_level_noclr)  // R07
         else $error("clear took effect while level active");

      property p_w1c_clears;
         flags_r[c] && clr_req[c] && !set_evt[c] |=> !flags_r[c];
      endproperty
      a_w1c_clears: assert property (p_w1c_clears)  // R06
         else $error("write-one did not clear the flag");

      property p_no_spurious;
         $rose(flags_r[c]) |-> $past(routed_any[c]);
      endproperty
      a_no_spurious: assert property (p_no_spurious)  // R02
         else $error("flag rose with no routed pin");
   end

   property p_pd_block;
      (|(flags_r & wake_r)) |-> !pd_entry_ok;
   endproperty
   a_pd_block: assert property (p_pd_block)  // R11
      else $error("power-down allowed with wake flag set");

   property p_wake;
      flags_r[0] && wake_r[0] |=> wake_req ##0 !pd_entry_ok || !pd_entry_req || !flags_r[0];
   endproperty
   a_wake: assert property (p_wake)  // R19
      else $error("wake-enabled flag gave no wake request");

   sequence s_rise0_start;
      $rose(pin_in[0]) && pin_routed[0] && sens_r[0] && pol_r[0] && !flags_r[0];
   endsequence
   sequence s_rise0_hold;
      (pin_in[0] && pin_routed[0] && sens_r[0] && pol_r[0] && !clr_req[0]) [*2];
   endsequence
   property p_sync_delay;
      s_rise0_start ##1 s_rise0_hold |=> flags_r[0];
   endproperty
   a_sync_delay: assert property (p_sync_delay)  // R20
      else $error("rising pin not flagged three cycles later");

   sequence s_rd_accept;
      hsel && hready && htrans[1] && !hwrite;
   endsequence
   sequence s_rd_answer;
      !hreadyout ##1 hreadyout;
   endsequence
   property p_rd_wait;
      s_rd_accept |=> s_rd_answer;
   endproperty
   a_rd_wait: assert property (p_rd_wait)  // one read wait state
      else $error("read answer not after one wait state");
endmodule

// ### verif/ext_pins_model.sv
// Purpose: far-side model of the external pins that feed the block
// Assumes: pins move just after a rising hclk edge, never on it
// Notes:   a pin holds the level last asked for; it starts high
`timescale 1ns/10ps
module ext_pins_model
   import ext_irq_pkg::*;
(
   input  wire logic                  hclk,
   input  wire ext_irq_pkg::pin_vec_t pin_want,
   output ext_irq_pkg::pin_vec_t      pin_out
);
   // pins idle high so a level-low reset setting sets nothing
   initial pin_out = '1;
   // follow the bench's request one edge later, like a slow board trace
   always @(posedge hclk) pin_out <= pin_want;
endmodule

// ### verif/external_interrupt_inputs_tb.sv
// Purpose: self-checking bench for the external interrupt block
// Assumes: one AHB-Lite master task set, hready tied to hreadyout
// Notes:   pin effects are awaited under a bounded count of cycles
`timescale 1ns/10ps
module external_interrupt_inputs_tb;
   import ext_irq_pkg::*;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hresp;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic        hreadyout;
   logic [31:0] hrdata;
   pin_vec_t    pin_want = '1;
   pin_vec_t    pin_in;
   pin_vec_t    pin_routed = '0;
   ch_vec_t     irq_req;
   logic        wake_req;
   logic        pd_entry_req = 1'b0;
   logic        pd_entry_ok;
   int          fails = 0;
   int          tests_run = 0;
   int          cyc = 0;
   logic [31:0] rd;
   // clock at 5 ns
   initial forever #2.5 hclk = ~hclk;
   ext_irq_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(HSIZE_WORD), .hready(hreadyout),
      .hwdata(hwdata), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .pin_in(pin_in), .pin_routed(pin_routed), .irq_req(irq_req),
      .wake_req(wake_req), .pd_entry_req(pd_entry_req), .pd_entry_ok(pd_entry_ok));
   ext_pins_model pins_u (.hclk(hclk), .pin_want(pin_want), .pin_out(pin_in));
   task automatic chk(input logic ok, input string msg);
      tests_run++;
      if (!ok) begin
         fails++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask
   // hold the phase until hready is seen high at a rising edge
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(negedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50) fails++;
      @(posedge hclk);
   endtask
   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= a;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      rd = hrdata;
   endtask
   task automatic rd_chk(input logic [31:0] a, input logic [31:0] e, input string msg);
      ahb(1'b0, a, 32'h0);
      chk(rd === e, msg);
   endtask
   // wait a bounded time for one request line to reach a level
   task automatic wait_irq(input int ch, input logic v, input string msg);
      int n;
      n = 0;
      while (irq_req[ch] !== v && n < 20) begin
         @(posedge hclk);
         n++;
      end
      chk(irq_req[ch] === v, msg);
   endtask
   task automatic t_reset();
      rd_chk(FLAGS_ADDR, 32'h0, "flags reset");
      rd_chk(WAKE_ADDR, 32'h0, "wake reset");
      rd_chk(SENS_ADDR, 32'h0, "sens reset");
      rd_chk(POL_ADDR, 32'h0, "pol reset");
      ahb(1'b1, 32'hE01FC150, 32'hF);
      rd_chk(32'hE01FC150, 32'h0, "unmapped read");
      chk(hresp === HRESP_OKAY, "response not okay");
      chk(irq_req === 4'h0, "irq after reset");
      $display("test reset done");
   endtask
   task automatic t_level();
      pin_routed <= 9'h001;
      pin_want[0] <= 1'b0;
      wait_irq(0, 1'b1, "level low set");
      ahb(1'b1, FLAGS_ADDR, 32'h1);
      repeat (4) @(posedge hclk);
      rd_chk(FLAGS_ADDR, 32'h1, "clear while active");
      pin_want[0] <= 1'b1;
      repeat (6) @(posedge hclk);
      ahb(1'b1, FLAGS_ADDR, 32'h1);
      rd_chk(FLAGS_ADDR, 32'h0, "clear once inactive");
      chk(irq_req === 4'h0, "irq dropped");
      $display("test level done");
   endtask
   task automatic t_edge();
      int p [4];
      p = '{1, 2, 5, 8};
      pin_routed <= 9'h000;
      pin_want <= 9'h1DC;
      ahb(1'b1, SENS_ADDR, 32'hF);
      ahb(1'b1, POL_ADDR, 32'h5);
      pin_routed <= 9'h126;
      repeat (6) @(posedge hclk);
      ahb(1'b1, FLAGS_ADDR, 32'hF);
      pin_want[0] <= 1'b1;
      repeat (6) @(posedge hclk);
      chk(irq_req === 4'h0, "unrouted pin ignored");
      for (int c = 0; c < 4; c++) begin
         pin_want[p[c]] <= ~c[0];
         wait_irq(c, 1'b1, "edge sets flag");
         pin_want[p[c]] <= c[0];
         repeat (6) @(posedge hclk);
         chk(irq_req === (4'h1 << c), "edge flag sticky, one channel");
         ahb(1'b1, FLAGS_ADDR, 32'hF);
         @(negedge hclk);
         chk(irq_req === 4'h0, "edge flag cleared");
      end
      $display("test edge done");
   endtask
   task automatic t_wake();
      ahb(1'b1, WAKE_ADDR, 32'h2);
      rd_chk(WAKE_ADDR, 32'h2, "wake enable");
      pd_entry_req <= 1'b1;
      @(posedge hclk);
      chk(pd_entry_ok === 1'b1, "power-down allowed");
      pin_want[1] <= 1'b1;
      pin_want[2] <= 1'b0;
      wait_irq(1, 1'b1, "wake channel set");
      wait_irq(0, 1'b1, "plain channel set");
      repeat (2) @(posedge hclk);
      chk(wake_req === 1'b1, "wake raised");
      chk(pd_entry_ok === 1'b0, "power-down refused");
      ahb(1'b1, FLAGS_ADDR, 32'h2);
      repeat (2) @(posedge hclk);
      chk(wake_req === 1'b0, "no wake from plain channel");
      chk(pd_entry_ok === 1'b1 && irq_req === 4'h1, "power-down allowed again");
      $display("test wake done");
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // cut a hang short
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         print_verdict();
      end
   end
   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset();
      t_level();
      t_edge();
      t_wake();
      print_verdict();
   end
endmodule
